// file: rtl/rtc_sec_min_pkg.sv
/*
  Package for the seconds/minutes time counter block: register map,
  field layout, timing constants and shared types.
  Assumes a single 250 MHz core clock and an AHB-Lite register bus.
*/
package rtc_sec_min_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] seconds_count_addr = 8'h00;
  localparam logic [7:0] minutes_count_addr = 8'h04;
  localparam logic [7:0] counter_control_addr = 8'h08;
  localparam logic [7:0] hour_carry_count_addr = 8'h0C;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int busy_bit = 7;
  localparam logic [3:0] units_max = 4'h9;
  localparam logic [2:0] tens_max = 3'h5;
  localparam logic [3:0] units_zero = 4'h0;
  localparam logic [2:0] tens_zero = 3'h0;
  localparam logic [6:0] digits_zero = 7'h00;

  // Control register bits
  localparam int ctrl_run_bit = 0;
  localparam int ctrl_free_run_bit = 1;
  localparam int ctrl_soft_reset_bit = 2;
  localparam logic [2:0] ctrl_reset_value = 3'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int clk_freq_mhz = 250;
  localparam int tick_period_s = 1;
  localparam int tick_cycles_default = tick_period_s * clk_freq_mhz * 1000000;
  localparam int busy_cycles = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0] tens;
    logic [3:0] units;
  } bcd_pair_type;

  typedef struct packed
  {
    logic write;
    logic [7:0] addr;
  } bus_req_type;

endpackage

// file: rtl/rtc_tick_gen.sv
/*
  One-second tick generator: divides the core clock into a one-cycle
  pulse. Assumes the caller holds run low to stop the count.
*/
`timescale 1ns/10ps

module rtc_tick_gen #(
  parameter int tick_cycles = rtc_sec_min_pkg::tick_cycles_default
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic clear,
  output logic tick
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (clear)
    begin
      next_count = 32'h00000000;
    end
    else if (run)
    begin
      if (count == 32'(tick_cycles - 1))
      begin
        next_count = 32'h00000000;
        next_tick = 1'b1;
      end
      else
      begin
        next_count = count + 32'h00000001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

// file: rtl/rtc_bcd_digit_pair.sv
/*
  Two-digit BCD counter 00..59 with load and clear.
  Assumes load and step never matter together: load wins.
*/
`timescale 1ns/10ps

module rtc_bcd_digit_pair
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic load,
  input wire rtc_sec_min_pkg::bcd_pair_type load_value,
  input wire logic step,
  output rtc_sec_min_pkg::bcd_pair_type value,
  output logic carry
);

  rtc_sec_min_pkg::bcd_pair_type next_value;

  always_comb
  begin
    next_value = value;
    carry = 1'b0;
    if (clear)
    begin
      next_value = rtc_sec_min_pkg::digits_zero;
    end
    else if (load)
    begin
      next_value = load_value;
    end
    else if (step)
    begin
      if (value.units == rtc_sec_min_pkg::units_max)
      begin
        next_value.units = rtc_sec_min_pkg::units_zero;
        if (value.tens == rtc_sec_min_pkg::tens_max)
        begin
          next_value.tens = rtc_sec_min_pkg::tens_zero;
          carry = 1'b1;
        end
        else
        begin
          next_value.tens = value.tens + 3'h1;
        end
      end
      else
      begin
        next_value.units = value.units + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      value <= rtc_sec_min_pkg::digits_zero;
    end
    else
    begin
      value <= next_value;
    end
  end

endmodule

// file: rtl/rtc_sec_min.sv
/*
  Seconds and minutes time counter with an AHB-Lite register slave.
  Holds BCD seconds and minutes, an 8-bit free-running mode, a busy
  flag during updates, a soft reset bit and the carry into hours.
  Assumes one 250 MHz clock, synchronous active-low reset, and a
  single-word-only AHB-Lite master.
*/
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps

module rtc_sec_min #(
  parameter int tick_cycles = rtc_sec_min_pkg::tick_cycles_default
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic hour_carry
);

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  rtc_sec_min_pkg::bus_req_type req;
  rtc_sec_min_pkg::bus_req_type next_req;
  logic req_valid;
  logic next_req_valid;
  logic addr_phase;

  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    next_req_valid = addr_phase;
    next_req = req;
    if (addr_phase)
    begin
      next_req.write = hwrite;
      next_req.addr = haddr[7:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      req_valid <= 1'b0;
      req <= '0;
    end
    else
    begin
      req_valid <= next_req_valid;
      req <= next_req;
    end
  end

  logic wr_en;
  logic rd_en;
  assign wr_en = req_valid && req.write;
  assign rd_en = addr_phase && !hwrite;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic soft_counter_reset;
  logic run;
  logic free_run;

  assign run = ctrl[rtc_sec_min_pkg::ctrl_run_bit];
  assign free_run = ctrl[rtc_sec_min_pkg::ctrl_free_run_bit];
  // Soft reset is a self-clearing write strobe
  assign soft_counter_reset = wr_en
    && req.addr == rtc_sec_min_pkg::counter_control_addr
    && hwdata[rtc_sec_min_pkg::ctrl_soft_reset_bit];

  always_comb
  begin
    next_ctrl = ctrl;
    next_ctrl[rtc_sec_min_pkg::ctrl_soft_reset_bit] = 1'b0;
    if (wr_en && req.addr == rtc_sec_min_pkg::counter_control_addr)
    begin
      next_ctrl[rtc_sec_min_pkg::ctrl_run_bit] =
        hwdata[rtc_sec_min_pkg::ctrl_run_bit];
      next_ctrl[rtc_sec_min_pkg::ctrl_free_run_bit] =
        hwdata[rtc_sec_min_pkg::ctrl_free_run_bit];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctrl <= rtc_sec_min_pkg::ctrl_reset_value;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // Tick and counters
  // ----------------------------------------------------------------------
  logic tick;
  logic sec_step;
  logic min_step;
  logic sec_carry;
  logic min_carry;
  logic sec_load;
  logic min_load;
  rtc_sec_min_pkg::bcd_pair_type sec_value;
  rtc_sec_min_pkg::bcd_pair_type min_value;
  rtc_sec_min_pkg::bcd_pair_type wr_digits;
  logic [7:0] free_count;
  logic [7:0] next_free_count;

  rtc_tick_gen #(
    .tick_cycles(tick_cycles)
  ) u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(run),
    .clear(soft_counter_reset),
    .tick(tick)
  );

  assign wr_digits = hwdata[6:0];
  assign sec_load = wr_en
    && req.addr == rtc_sec_min_pkg::seconds_count_addr;
  assign min_load = wr_en
    && req.addr == rtc_sec_min_pkg::minutes_count_addr;
  assign sec_step = tick && !free_run;
  assign min_step = sec_carry;

  rtc_bcd_digit_pair u_seconds (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(soft_counter_reset),
    .load(sec_load && !free_run),
    .load_value(wr_digits),
    .step(sec_step),
    .value(sec_value),
    .carry(sec_carry)
  );

  rtc_bcd_digit_pair u_minutes (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(soft_counter_reset),
    .load(min_load),
    .load_value(wr_digits),
    .step(min_step),
    .value(min_value),
    .carry(min_carry)
  );

  // Free-running 8-bit mode of the seconds register
  always_comb
  begin
    next_free_count = free_count;
    if (soft_counter_reset)
    begin
      next_free_count = 8'h00;
    end
    else if (sec_load && free_run)
    begin
      next_free_count = {1'b0, hwdata[6:0]};
    end
    else if (tick && free_run)
    begin
      next_free_count = free_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Busy flag and hour carry
  // ----------------------------------------------------------------------
  logic [1:0] busy_count;
  logic [1:0] next_busy_count;
  logic busy;
  logic next_hour_carry;
  logic [7:0] hour_events;
  logic [7:0] next_hour_events;

  assign busy = busy_count != 2'h0;

  always_comb
  begin
    next_busy_count = busy_count;
    next_hour_carry = min_carry;
    next_hour_events = hour_events;
    if (soft_counter_reset)
    begin
      next_busy_count = 2'h0;
      next_hour_events = 8'h00;
    end
    else
    begin
      if (tick)
      begin
        next_busy_count = 2'(rtc_sec_min_pkg::busy_cycles);
      end
      else if (busy)
      begin
        next_busy_count = busy_count - 2'h1;
      end
      if (min_carry)
      begin
        next_hour_events = hour_events + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      free_count <= 8'h00;
      busy_count <= 2'h0;
      hour_carry <= 1'b0;
      hour_events <= 8'h00;
    end
    else
    begin
      free_count <= next_free_count;
      busy_count <= next_busy_count;
      hour_carry <= next_hour_carry;
      hour_events <= next_hour_events;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] next_hrdata;

  always_comb
  begin
    next_hrdata = 32'h00000000;
    if (rd_en)
    begin
      unique case (haddr[7:0])
        rtc_sec_min_pkg::seconds_count_addr:
        begin
          if (free_run)
          begin
            next_hrdata[7:0] = free_count;
          end
          else
          begin
            next_hrdata[7:0] = {busy, sec_value};
          end
        end
        rtc_sec_min_pkg::minutes_count_addr:
        begin
          next_hrdata[7:0] = {busy, min_value};
        end
        rtc_sec_min_pkg::counter_control_addr:
        begin
          next_hrdata[2:0] = ctrl;
        end
        rtc_sec_min_pkg::hour_carry_count_addr:
        begin
          next_hrdata[7:0] = hour_events;
        end
        default:
        begin
          next_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      hrdata <= 32'h00000000;
    end
    else
    begin
      hrdata <= next_hrdata;
    end
  end

endmodule

// file: testbench/rtc_sec_min_assertions.sv
/*
  Port checker for the seconds/minutes counter block.
  Assumes zero-wait AHB-Lite transfers and BCD-only writes.
*/
`timescale 1ns/10ps

module rtc_sec_min_assertions #(
  parameter int tick_cycles = rtc_sec_min_pkg::tick_cycles_default
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic hour_carry
);
  logic rd_q;
  logic wr_q;
  logic free_q;
  logic [7:0] a_q;

  // --------------------------------
  // Data phase tracking
  // --------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      free_q <= 1'b0;
      a_q <= 8'h00;
    end
    else
    begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h08)
        free_q <= hwdata[1];
    end
  end

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_b |=> hrdata == 32'h0 && !hour_carry)
    else $error("outputs not cleared by reset");
  idle_zero_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read");
  upper_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (
    rd_q && a_q >= 8'h10 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  sec_bcd_a: assert property (
    rd_q && a_q == 8'h00 && !free_q |->
    hrdata[6:4] <= 3'h5 && hrdata[3:0] <= 4'h9)
    else $error("seconds out of range");
  min_bcd_a: assert property (
    rd_q && a_q == 8'h04 |-> hrdata[6:4] <= 3'h5 && hrdata[3:0] <= 4'h9)
    else $error("minutes out of range");
  carry_pulse_a: assert property ($rose(hour_carry) |=> $fell(hour_carry))
    else $error("hour carry longer than one cycle");

  cover property (rd_q && a_q == 8'h00 && hrdata[7]);
  cover property ($rose(hour_carry));
  cover property (wr_q && a_q == 8'h08 && hwdata[2]);
endmodule

// file: testbench/testbench.sv
/*
  Self-checking bench for the seconds/minutes counter block.
  Assumes a zero-wait AHB-Lite slave and a tick every 8 cycles.
*/
`timescale 1ns/10ps

module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hour_carry;
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int carries = 0;

  rtc_sec_min #(.tick_cycles(8)) dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hour_carry(hour_carry)
  );

  always #2 core_clk = ~core_clk;

  // --------------------------------
  // Cycle limit and carry counting
  // --------------------------------
  always @(posedge core_clk)
  begin
    cycles++;
    if (hour_carry === 1'b1)
      carries++;
    if (cycles == 6000)
    begin
      n_errors++;
      final_report();
    end
  end

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic advance(input logic f, input logic [7:0] s, m, es, em,
                         input int ec);
    int c0;
    int n;
    bus(1'b1, 8'h08, {30'h0, f, 1'b0});
    bus(1'b1, 8'h00, {24'h0, s});
    bus(1'b1, 8'h04, {24'h0, m});
    c0 = carries;
    bus(1'b1, 8'h08, {30'h0, f, 1'b1});
    n = 0;
    do
    begin
      bus(1'b0, 8'h00, 32'h0);
      n++;
    end
    while (rd[6:0] === s[6:0] && n < 20);
    bus(1'b1, 8'h08, {30'h0, f, 1'b0});
    expect_rd(8'h00, {24'h0, es});
    expect_rd(8'h04, {24'h0, em});
    check(32'(carries - c0), 32'(ec));
  endtask

  task automatic busy_scan(input logic [7:0] a);
    int hits;
    hits = 0;
    bus(1'b1, 8'h08, 32'h1);
    repeat (12)
    begin
      bus(1'b0, a, 32'h0);
      if (rd[7] === 1'b1)
        hits++;
    end
    check(32'(hits > 0), 32'h1);
    bus(1'b1, 8'h08, 32'h0);
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    expect_rd(8'h08, 32'h1);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'hD9);
    expect_rd(8'h00, 32'h59);
    bus(1'b1, 8'h04, 32'hA5);
    expect_rd(8'h04, 32'h25);
    bus(1'b1, 8'h08, 32'h4);
    expect_rd(8'h00, 32'h0);
    expect_rd(8'h04, 32'h0);
    expect_rd(8'h08, 32'h0);
    bus(1'b1, 8'h14, 32'hFF);
    expect_rd(8'h14, 32'h0);
    expect_rd(8'h10, 32'h0);
    advance(1'b0, 8'h00, 8'h00, 8'h01, 8'h00, 0);
    advance(1'b0, 8'h09, 8'h30, 8'h10, 8'h30, 0);
    advance(1'b0, 8'h59, 8'h09, 8'h00, 8'h10, 0);
    advance(1'b0, 8'h59, 8'h59, 8'h00, 8'h00, 1);
    expect_rd(8'h0C, 32'h1);
    advance(1'b1, 8'h7F, 8'h12, 8'h80, 8'h12, 0);
    busy_scan(8'h00);
    busy_scan(8'h04);
    final_report();
  end
endmodule

bind rtc_sec_min rtc_sec_min_assertions #(.tick_cycles(tick_cycles)) chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hour_carry(hour_carry)
);
